/* common/hsft_pkg.sv */
/*
 * constants, codes and types for the hot swap fault timer control block.
 * assumes a 10 MHz system clock and comparator levels from the analog side.
 */
// Behaviour
// RQ1: high limit at low drain, low at high
// RQ2: fast trip pulls main gate low at once
// RQ3: select pin picks 25/40 mV and 2x/3x
// RQ4: off and insertion: switch open, node discharged
// RQ5: start-up closes soft start to gate switch
// RQ6: normal: node floating, switch open, no discharge
// RQ7: outside current limit timer sinks small current
// RQ8: in limit timer sources low or high current
// RQ9: timeout at high or lower threshold by drain
// RQ10: timeout runs 64 recharge cycles then restarts
// RQ11: enable toggling never aborts the cool-down cycles
// RQ12: reset with low timer starts without discharge
// RQ13: reset with charged timer cools down first
// RQ14: aux gate only once main gate fully on
// RQ15: timer runs from slightly positive gate current
// RQ16: power good needs both gates and low drain
// RQ17: start-up forces low limit and low fast trip
// RQ18: comparators synchronised, source enables registered
// RQ19: saturating cycle counter, done on final recharge
package hsft_pkg;

	// timing
	localparam int CLK_HZ        = 10_000_000;    // system clock rate
	localparam int INS_DELAY_MS  = 32;            // insertion delay, ms
	localparam int INS_DELAY_CYC = INS_DELAY_MS * (CLK_HZ / 1000);
	localparam int SYNC_STAGES   = 2;             // synchroniser depth
	localparam int SETTLE_CYC    = 3;             // wait for synchroniser fill

	// cool-down cycle counting
	localparam int COOL_CYCLES = 64;
	localparam int COUNT_W     = 7;

	// register offsets, byte addresses
	localparam logic [7:0] ADDR_STATUS    = 8'h00;
	localparam logic [7:0] ADDR_CONTROL   = 8'h04;
	localparam logic [7:0] ADDR_INT_STAT  = 8'h08;
	localparam logic [7:0] ADDR_INT_CLEAR = 8'h0C;
	localparam logic [7:0] ADDR_INT_EN    = 8'h10;

	// reset values
	localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
	localparam logic [3:0]  INT_EN_RST  = 4'h0;

	// field positions
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_COUNT_LSB = 8;
	localparam int STAT_PG_BIT    = 16;
	localparam int CTRL_HOLD_BIT  = 0;
	localparam int NUM_EVENTS     = 4;
	localparam int EV_TIMEOUT     = 0;
	localparam int EV_FAST_TRIP   = 1;
	localparam int EV_COOL_DONE   = 2;
	localparam int EV_PG_RISE     = 3;

	// threshold select pin as seen by the pin sensing circuit
	typedef enum logic [1:0] {
		THR_FLOAT   = 2'b00,  // 25 mV, fast trip 2x
		THR_RES_A   = 2'b01,  // 25 mV, fast trip 3x
		THR_RES_B   = 2'b10,  // 40 mV, fast trip 3x
		THR_TIED    = 2'b11   // 40 mV, fast trip 2x
	} hsft_thresh_type;

	// operating states
	typedef enum logic [3:0] {
		ST_POR_CHECK  = 4'b0000,
		ST_OFF        = 4'b0001,
		ST_INS_DELAY  = 4'b0010,
		ST_STARTUP    = 4'b0011,
		ST_NORMAL     = 4'b0100,
		ST_COOL_DIS   = 4'b0101,
		ST_COOL_CHG   = 4'b0110,
		ST_COOL_FLUSH = 4'b0111
	} hsft_state_type;

endpackage

/* hw/hsft_sync.sv */
/*
 * two-stage synchroniser for a bundle of comparator levels.
 * assumes each bit is a slow level; no pulse is caught reliably.
 */
`timescale 1ns/1ps
module hsft_sync
	import hsft_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             SYS_CLK,
	input  wire logic [WIDTH-1:0] ASYNC_IN,
	output logic      [WIDTH-1:0] SYNC_OUT
);

	logic [WIDTH-1:0] meta_ff;   // first stage, read only by second

	// no reset: data path only, the control waits for the fill
	always_ff @(posedge SYS_CLK)
	begin
		meta_ff  <= ASYNC_IN;
		SYNC_OUT <= meta_ff;
	end

endmodule

/* hw/hsft_ctrl.sv */
/*
 * hot swap control: state sequencing, timer source steering, soft start
 * switch, current limit selection, aux gate and a small register port.
 * assumes analog comparators and switches outside, one 10 MHz clock.
 */
`timescale 1ns/1ps
module hsft_ctrl
	import hsft_pkg::*;
#(
	parameter int INS_DELAY_CYCLES = INS_DELAY_CYC
)
(
	input  wire logic        SYS_CLK,
	input  wire logic        RESET,
	input  wire logic [1:0]  THRESH_SEL_CODE,
	input  wire logic        SNS_IN_LIMIT,
	input  wire logic        SNS_FAST_TRIP,
	input  wire logic        DRAIN_ABOVE_LIMIT_SW,
	input  wire logic        DRAIN_ABOVE_TIMER_SW,
	input  wire logic        TMR_ABOVE_HIGH,
	input  wire logic        TMR_ABOVE_TRIP_LOW,
	input  wire logic        TMR_ABOVE_LOW,
	input  wire logic        TMR_ABOVE_ZERO,
	input  wire logic        GATE_BELOW_TH,
	input  wire logic        MAIN_GATE_HIGH,
	input  wire logic        AUX_GATE_HIGH,
	input  wire logic        INPUT_VALID,
	input  wire logic        POWER_GOOD_DEGL,
	input  wire logic [7:0]  ADDR,
	input  wire logic [31:0] WR_DATA,
	input  wire logic        WR_STB,
	input  wire logic        RD_STB,
	output logic      [31:0] RD_DATA,
	output logic             IRQ,
	output logic             MAIN_GATE_EN,
	output logic             MAIN_GATE_PULL_LOW,
	output logic             AUX_GATE_EN,
	output logic             SS_TO_GATE_SW,
	output logic             SS_DISCHARGE_EN,
	output logic             TMR_SINK_SMALL_EN,
	output logic             TMR_SRC_LOW_EN,
	output logic             TMR_SRC_HIGH_EN,
	output logic             TMR_FULL_DISCH_EN,
	output logic             HIGH_LIMIT_SEL,
	output logic             HIGH_LIMIT_40MV_SEL,
	output logic             FAST_TRIP_X3_SEL,
	output logic             FAST_TRIP_LOW_SEL,
	output logic             POWER_GOOD_INTERNAL
);

	localparam int DW = $clog2(INS_DELAY_CYCLES + 1);
	localparam logic [DW-1:0] DELAY_LAST = DW'(INS_DELAY_CYCLES - 1);
	localparam logic [COUNT_W-1:0] COUNT_LAST = COUNT_W'(COOL_CYCLES - 1);
	localparam logic [COUNT_W-1:0] COUNT_MAX  = COUNT_W'(COOL_CYCLES);
	localparam logic [1:0] SETTLE_LAST = 2'(SETTLE_CYC - 1);

	// synchronised comparator levels
	logic [14:0]     sync_bus;
	logic [1:0]      thr_s;          // threshold select code
	logic            lim_s;          // sense at current limit
	logic            ft_s;           // sense above fast trip
	logic            drain_lim_s;    // drain above limit switch level
	logic            drain_tmr_s;    // drain above timer switch level
	logic            tmr_high_s;     // timer at high level
	logic            tmr_trip_s;     // timer at lower trip level
	logic            tmr_low_s;      // timer above low level
	logic            tmr_zero_s;     // timer not yet empty
	logic            gate_low_s;     // gate below its threshold
	logic            main_high_s;    // main gate fully enhanced
	logic            aux_high_s;     // aux gate high
	logic            valid_s;        // input and supply in range
	logic            pgd_s;          // filtered power good

	// state and counters
	hsft_state_type  st_ff;
	hsft_state_type  nxt_st;
	logic [DW-1:0]   delay_cnt_ff;   // insertion delay count
	logic [COUNT_W-1:0] cool_cnt_ff; // cool-down cycles done
	logic [1:0]      settle_ff;      // wait after reset
	logic            pg_prev_ff;     // for power good rise event

	// registers
	logic            hold_off_ff;    // software holds the switch off
	logic [3:0]      int_stat_ff;    // sticky events
	logic [3:0]      int_en_ff;      // event enables

	// derived terms
	logic            running;        // gate driven phases
	logic            timing_out;     // timer reached its threshold
	logic            cool_last;      // final recharge reached high level
	logic            pg_now;         // internal power good, unregistered
	logic [3:0]      events;

	hsft_sync #(
		.WIDTH (15)
	) hsft_sync_inst (
		.SYS_CLK  (SYS_CLK),
		.ASYNC_IN ({THRESH_SEL_CODE, SNS_IN_LIMIT, SNS_FAST_TRIP,
			DRAIN_ABOVE_LIMIT_SW, DRAIN_ABOVE_TIMER_SW, TMR_ABOVE_HIGH,
			TMR_ABOVE_TRIP_LOW, TMR_ABOVE_LOW, TMR_ABOVE_ZERO,
			GATE_BELOW_TH, MAIN_GATE_HIGH, AUX_GATE_HIGH, INPUT_VALID,
			POWER_GOOD_DEGL}),              // see RQ18
		.SYNC_OUT (sync_bus)
	);

	assign {thr_s, lim_s, ft_s, drain_lim_s, drain_tmr_s, tmr_high_s,
		tmr_trip_s, tmr_low_s, tmr_zero_s, gate_low_s, main_high_s,
		aux_high_s, valid_s, pgd_s} = sync_bus;

	// only start-up and normal drive the main gate
	assign running = (st_ff == ST_STARTUP) || (st_ff == ST_NORMAL);

	// lower threshold applies while the drain sits high
	assign timing_out = running &&
		(drain_tmr_s ? tmr_trip_s : tmr_high_s);     // see RQ9

	assign cool_last = (st_ff == ST_COOL_CHG) && tmr_high_s &&
		(cool_cnt_ff == COUNT_LAST);                  // see RQ19

	// both gates up and drain low
	assign pg_now = main_high_s && aux_high_s && !drain_tmr_s; // see RQ16

	assign events = {pg_now && !pg_prev_ff, cool_last,
		ft_s && running, timing_out};

	// next state
	always_comb
	begin
		nxt_st = st_ff;
		case (st_ff)
			ST_POR_CHECK:
				// timer level decides between cool-down and plain start
				if (settle_ff == SETTLE_LAST)
					nxt_st = tmr_low_s ? ST_COOL_DIS   // see RQ13
						: ST_OFF;                      // see RQ12
			ST_OFF:
				if (valid_s && !hold_off_ff)
					nxt_st = ST_INS_DELAY;
			ST_INS_DELAY:
				if (!valid_s || hold_off_ff)
					nxt_st = ST_OFF;
				else if (delay_cnt_ff == DELAY_LAST)
					nxt_st = ST_STARTUP;
			ST_STARTUP:
				// timeout wins, then faults, then power good
				if (timing_out)
					nxt_st = ST_COOL_DIS;
				else if (!valid_s || ft_s || hold_off_ff)
					nxt_st = ST_OFF;
				else if (pgd_s)
					nxt_st = ST_NORMAL;
			ST_NORMAL:
				// brief faults only drop the gate, not the state
				if (timing_out)
					nxt_st = ST_COOL_DIS;
				else if (!pgd_s || hold_off_ff)
					nxt_st = ST_OFF;
			ST_COOL_DIS:
				if (!tmr_low_s)
					nxt_st = ST_COOL_CHG;
			ST_COOL_CHG:
				// enable changes are ignored until the count ends
				if (cool_last)
					nxt_st = ST_COOL_FLUSH;        // see RQ10 RQ11
				else if (tmr_high_s)
					nxt_st = ST_COOL_DIS;
			ST_COOL_FLUSH:
				// restart straight away once the timer is empty
				if (!tmr_zero_s)
					nxt_st = (valid_s && !hold_off_ff) ? ST_STARTUP
						: ST_OFF;                      // see RQ11
			default:
				nxt_st = ST_OFF;
		endcase
	end

	// state register
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
			st_ff <= ST_POR_CHECK;
		else
			st_ff <= nxt_st;
	end

	// settle wait so the check sees real timer levels
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
			settle_ff <= 2'h0;
		else if (settle_ff != SETTLE_LAST)
			settle_ff <= settle_ff + 2'h1;
	end

	// insertion delay counter, runs only in its state
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET || st_ff != ST_INS_DELAY)
			delay_cnt_ff <= '0;
		else if (delay_cnt_ff != DELAY_LAST)
			delay_cnt_ff <= delay_cnt_ff + DW'(1);
	end

	// cool-down counter, cleared on timeout entry
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET || (running && timing_out))
			cool_cnt_ff <= '0;                     // see RQ19
		else if (st_ff == ST_COOL_CHG && tmr_high_s &&
			cool_cnt_ff != COUNT_MAX)
			cool_cnt_ff <= cool_cnt_ff + COUNT_W'(1); // see RQ10
	end

	// gate drive and aux gate
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
		begin
			MAIN_GATE_EN       <= 1'b0;
			MAIN_GATE_PULL_LOW <= 1'b0;
			AUX_GATE_EN        <= 1'b0;
		end
		else
		begin
			// fast trip overrides regulation; invalid input drops gate too
			MAIN_GATE_EN       <= running && !ft_s && valid_s &&
				!hold_off_ff;                           // see RQ2
			MAIN_GATE_PULL_LOW <= ft_s || !running;    // see RQ2
			// aux only in normal with the main FET fully on
			AUX_GATE_EN        <= (st_ff == ST_NORMAL) && main_high_s &&
				!ft_s && valid_s;                       // see RQ14
		end
	end

	// soft start switch and discharge by phase
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
		begin
			SS_TO_GATE_SW   <= 1'b0;
			SS_DISCHARGE_EN <= 1'b1;
		end
		else
		begin
			SS_TO_GATE_SW   <= (st_ff == ST_STARTUP);  // see RQ5 RQ6
			// normal leaves the node alone to keep transients clean
			SS_DISCHARGE_EN <= !running;               // see RQ4 RQ6
		end
	end

	// timer current sources
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
		begin
			TMR_SINK_SMALL_EN <= 1'b0;
			TMR_SRC_LOW_EN    <= 1'b0;
			TMR_SRC_HIGH_EN   <= 1'b0;
			TMR_FULL_DISCH_EN <= 1'b0;
		end
		else
		begin
			TMR_SINK_SMALL_EN <= 1'b0;
			TMR_SRC_LOW_EN    <= 1'b0;
			TMR_SRC_HIGH_EN   <= 1'b0;
			TMR_FULL_DISCH_EN <= 1'b0;
			case (st_ff)
				// limit comparator trips at slightly positive gate current
				ST_STARTUP, ST_NORMAL:
					if (lim_s && gate_low_s)           // see RQ15
					begin
						TMR_SRC_HIGH_EN <= drain_lim_s;  // see RQ8
						TMR_SRC_LOW_EN  <= !drain_lim_s; // see RQ8
					end
					else
						TMR_SINK_SMALL_EN <= 1'b1;     // see RQ7
				ST_OFF, ST_INS_DELAY, ST_COOL_DIS:
					TMR_SINK_SMALL_EN <= 1'b1;         // see RQ7 RQ10
				ST_COOL_CHG:
					TMR_SRC_LOW_EN <= 1'b1;            // see RQ10
				ST_COOL_FLUSH:
					TMR_FULL_DISCH_EN <= 1'b1;         // see RQ10
				// reset check leaves the timer untouched
				default:
					TMR_SINK_SMALL_EN <= 1'b0;         // see RQ12
			endcase
		end
	end

	// limit and fast trip level selection
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
		begin
			HIGH_LIMIT_SEL      <= 1'b0;
			HIGH_LIMIT_40MV_SEL <= 1'b0;
			FAST_TRIP_X3_SEL    <= 1'b0;
			FAST_TRIP_LOW_SEL   <= 1'b1;
		end
		else
		begin
			// start-up always low; in normal the limit follows the drain, fast trip stays full
			HIGH_LIMIT_SEL      <= (st_ff == ST_NORMAL) &&
				!drain_lim_s;                           // see RQ1 RQ17
			FAST_TRIP_LOW_SEL   <= (st_ff != ST_NORMAL); // see RQ17
			HIGH_LIMIT_40MV_SEL <= thr_s[1];           // see RQ3
			FAST_TRIP_X3_SEL    <= (thr_s == THR_RES_A) ||
				(thr_s == THR_RES_B);                   // see RQ3
		end
	end

	// internal power good
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
		begin
			POWER_GOOD_INTERNAL <= 1'b0;
			pg_prev_ff          <= 1'b0;
		end
		else
		begin
			POWER_GOOD_INTERNAL <= pg_now;             // see RQ16
			pg_prev_ff          <= pg_now;
		end
	end

	// control and enable registers
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
		begin
			hold_off_ff <= CONTROL_RST[CTRL_HOLD_BIT];
			int_en_ff   <= INT_EN_RST;
		end
		else if (WR_STB)
		begin
			if (ADDR == ADDR_CONTROL)
				hold_off_ff <= WR_DATA[CTRL_HOLD_BIT];
			if (ADDR == ADDR_INT_EN)
				int_en_ff <= WR_DATA[NUM_EVENTS-1:0];
		end
	end

	// sticky events; a new event beats a clear in the same cycle
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
			int_stat_ff <= 4'h0;
		else if (WR_STB && ADDR == ADDR_INT_CLEAR)
			int_stat_ff <= (int_stat_ff & ~WR_DATA[NUM_EVENTS-1:0]) |
				events;
		else
			int_stat_ff <= int_stat_ff | events;
	end

	// interrupt level from the registered status
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
			IRQ <= 1'b0;
		else
			IRQ <= |(int_stat_ff & int_en_ff);
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET || !RD_STB)
			RD_DATA <= 32'h0000_0000;
		else
			case (ADDR)
				ADDR_STATUS:
				begin
					RD_DATA <= 32'h0000_0000;
					RD_DATA[STAT_STATE_LSB +: 4] <= st_ff;
					RD_DATA[STAT_COUNT_LSB +: COUNT_W] <= cool_cnt_ff;
					RD_DATA[STAT_PG_BIT] <= POWER_GOOD_INTERNAL;
				end
				ADDR_CONTROL:
					RD_DATA <= {31'h0000_0000, hold_off_ff};
				ADDR_INT_STAT:
					RD_DATA <= {28'h000_0000, int_stat_ff};
				ADDR_INT_EN:
					RD_DATA <= {28'h000_0000, int_en_ff};
				// unmapped and write-only read as zero
				default:
					RD_DATA <= 32'h0000_0000;
			endcase
	end

	// checks
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RESET);

	sequence cool_final_s;
		st_ff == ST_COOL_CHG && tmr_high_s && cool_cnt_ff == COUNT_LAST;
	endsequence

	sequence flush_begin_s;
		st_ff == ST_COOL_FLUSH ##1 TMR_FULL_DISCH_EN;
	endsequence

	fast_trip_gate_a: assert property (ft_s && running |=> // see RQ2
		MAIN_GATE_PULL_LOW && !MAIN_GATE_EN)
		else $error("fast trip did not drop the main gate");
	limit_by_drain_a: assert property (st_ff == ST_NORMAL // see RQ1
		|=> HIGH_LIMIT_SEL == !$past(drain_lim_s))
		else $error("limit level does not follow drain");
	startup_low_a: assert property (st_ff == ST_STARTUP // see RQ17
		|=> !HIGH_LIMIT_SEL && FAST_TRIP_LOW_SEL && SS_TO_GATE_SW)
		else $error("start-up levels or switch wrong");
	ss_idle_a: assert property (!running |=> // see RQ4
		!SS_TO_GATE_SW && SS_DISCHARGE_EN)
		else $error("soft start node not held discharged");
	ss_normal_a: assert property (st_ff == ST_NORMAL |=> // see RQ6
		!SS_TO_GATE_SW && !SS_DISCHARGE_EN)
		else $error("soft start node touched in normal");
	timer_src_a: assert property (running && lim_s && gate_low_s // see RQ8
		|=> TMR_SRC_HIGH_EN == $past(drain_lim_s) && !TMR_SINK_SMALL_EN)
		else $error("timer source choice wrong");
	timer_sink_a: assert property (running && !lim_s // see RQ7
		|=> TMR_SINK_SMALL_EN && !TMR_SRC_LOW_EN && !TMR_SRC_HIGH_EN)
		else $error("timer not sinking outside limit");
	timeout_entry_a: assert property (timing_out |=> // see RQ9
		st_ff == ST_COOL_DIS && cool_cnt_ff == '0 ##1 TMR_SINK_SMALL_EN)
		else $error("timeout did not start cool-down");
	cool_finish_a: assert property (cool_final_s |=> // see RQ10
		flush_begin_s)
		else $error("cool-down did not end after last cycle");
	cool_hold_a: assert property (st_ff == ST_COOL_DIS && !valid_s // see RQ11
		|=> st_ff == ST_COOL_DIS || st_ff == ST_COOL_CHG)
		else $error("cool-down aborted by input change");
	por_path_a: assert property (st_ff == ST_POR_CHECK && // see RQ12
		settle_ff == SETTLE_LAST |=> (st_ff == ST_COOL_DIS) ==
		$past(tmr_low_s) ##1 !TMR_FULL_DISCH_EN)
		else $error("reset recovery path wrong");
	aux_gate_a: assert property (!main_high_s |=> !AUX_GATE_EN) // see RQ14
		else $error("aux gate on without main gate high");
	power_good_a: assert property (POWER_GOOD_INTERNAL |-> // see RQ16
		$past(main_high_s && aux_high_s && !drain_tmr_s))
		else $error("power good without its conditions");

endmodule

/* testbench/hsft_far_side.sv */
/*
 * behavioural far side of the hot swap block: timer cap and both gates.
 * assumes enables change just after SYS_CLK edges; rates are scaled up
 * so that one cool-down cycle takes about 300 clocks.
 */
`timescale 1ns/1ps
module hsft_far_side
(
	input  wire logic        SYS_CLK,
	input  wire logic        LOAD_EN,
	input  wire logic [11:0] LOAD_MV,
	input  wire logic        IN_LIMIT,
	input  wire logic        TMR_SINK_SMALL_EN,
	input  wire logic        TMR_SRC_LOW_EN,
	input  wire logic        TMR_SRC_HIGH_EN,
	input  wire logic        TMR_FULL_DISCH_EN,
	input  wire logic        MAIN_GATE_EN,
	input  wire logic        MAIN_GATE_PULL_LOW,
	input  wire logic        AUX_GATE_EN,
	output logic             TMR_ABOVE_HIGH,
	output logic             TMR_ABOVE_TRIP_LOW,
	output logic             TMR_ABOVE_LOW,
	output logic             TMR_ABOVE_ZERO,
	output logic             GATE_BELOW_TH,
	output logic             MAIN_GATE_HIGH,
	output logic             AUX_GATE_HIGH
);
	int tmr_mv_ff = 0;   // cap voltage, mV
	int gate_ff   = 0;   // main gate, volts
	int aux_ff    = 0;   // aux gate, volts

	// cap: sources win over the small sink, as in the analog block
	always_ff @(posedge SYS_CLK)
	begin
		if (LOAD_EN)
			tmr_mv_ff <= int'(LOAD_MV);
		else if (TMR_FULL_DISCH_EN)
			tmr_mv_ff <= (tmr_mv_ff > 100) ? tmr_mv_ff - 100 : 0;
		else if (TMR_SRC_HIGH_EN)
			tmr_mv_ff <= tmr_mv_ff + 100;
		else if (TMR_SRC_LOW_EN)
			tmr_mv_ff <= tmr_mv_ff + 20;
		else if (TMR_SINK_SMALL_EN)
			tmr_mv_ff <= (tmr_mv_ff > 4) ? tmr_mv_ff - 4 : 0;
	end

	// main gate: load in limit holds it below threshold
	always_ff @(posedge SYS_CLK)
	begin
		if (MAIN_GATE_PULL_LOW || !MAIN_GATE_EN)
			gate_ff <= 0;
		else if (IN_LIMIT)
			gate_ff <= 2;
		else if (gate_ff < 10)
			gate_ff <= gate_ff + 1;
	end

	// aux gate ramps only while enabled
	always_ff @(posedge SYS_CLK)
	begin
		if (!AUX_GATE_EN)
			aux_ff <= 0;
		else if (aux_ff < 10)
			aux_ff <= aux_ff + 1;
	end

	assign TMR_ABOVE_HIGH     = (tmr_mv_ff >= 1500);
	assign TMR_ABOVE_TRIP_LOW = (tmr_mv_ff >= 750);
	assign TMR_ABOVE_LOW      = (tmr_mv_ff >= 500);
	assign TMR_ABOVE_ZERO     = (tmr_mv_ff > 0);
	assign GATE_BELOW_TH      = (gate_ff < 3);
	assign MAIN_GATE_HIGH     = (gate_ff >= 10);
	assign AUX_GATE_HIGH      = (aux_ff >= 10);
endmodule

/* testbench/hsft_ctrl_bench.sv */
/*
 * self-checking bench for hsft_ctrl with the far side model.
 * assumes a 10 MHz clock and a short insertion delay of 20 cycles.
 */
`timescale 1ns/1ps
module hsft_ctrl_bench
	import hsft_pkg::*;
;
	logic        clk = 0, rst = 1, ld = 1, lim = 0, ft = 0;
	logic        dl = 0, dt = 0, vld = 0, pgd = 0, wr = 0, rd = 0;
	logic [1:0]  thr = 0;
	logic [11:0] lmv = 0;
	logic [7:0]  adr = 0;
	logic [31:0] wd = 0;
	wire  [31:0] rdd;
	wire         irq, gen, gpl, aen, ssw, ssd, snk, slo, shi, fls;
	wire         hl, l40, x3, ftl, pgi, th, ttl, tl, tz, gb, gh, ah;
	int          n_errors = 0;
	int          check_count = 0;

	always #50 clk = ~clk;

	hsft_ctrl #(.INS_DELAY_CYCLES(20)) hsft_ctrl_inst (
		.SYS_CLK(clk), .RESET(rst), .THRESH_SEL_CODE(thr),
		.SNS_IN_LIMIT(lim), .SNS_FAST_TRIP(ft),
		.DRAIN_ABOVE_LIMIT_SW(dl), .DRAIN_ABOVE_TIMER_SW(dt),
		.TMR_ABOVE_HIGH(th), .TMR_ABOVE_TRIP_LOW(ttl),
		.TMR_ABOVE_LOW(tl), .TMR_ABOVE_ZERO(tz), .GATE_BELOW_TH(gb),
		.MAIN_GATE_HIGH(gh), .AUX_GATE_HIGH(ah), .INPUT_VALID(vld),
		.POWER_GOOD_DEGL(pgd), .ADDR(adr), .WR_DATA(wd), .WR_STB(wr),
		.RD_STB(rd), .RD_DATA(rdd), .IRQ(irq), .MAIN_GATE_EN(gen),
		.MAIN_GATE_PULL_LOW(gpl), .AUX_GATE_EN(aen),
		.SS_TO_GATE_SW(ssw), .SS_DISCHARGE_EN(ssd),
		.TMR_SINK_SMALL_EN(snk), .TMR_SRC_LOW_EN(slo),
		.TMR_SRC_HIGH_EN(shi), .TMR_FULL_DISCH_EN(fls),
		.HIGH_LIMIT_SEL(hl), .HIGH_LIMIT_40MV_SEL(l40),
		.FAST_TRIP_X3_SEL(x3), .FAST_TRIP_LOW_SEL(ftl),
		.POWER_GOOD_INTERNAL(pgi));

	hsft_far_side hsft_far_side_inst (
		.SYS_CLK(clk), .LOAD_EN(ld), .LOAD_MV(lmv), .IN_LIMIT(lim),
		.TMR_SINK_SMALL_EN(snk), .TMR_SRC_LOW_EN(slo),
		.TMR_SRC_HIGH_EN(shi), .TMR_FULL_DISCH_EN(fls),
		.MAIN_GATE_EN(gen), .MAIN_GATE_PULL_LOW(gpl), .AUX_GATE_EN(aen),
		.TMR_ABOVE_HIGH(th), .TMR_ABOVE_TRIP_LOW(ttl),
		.TMR_ABOVE_LOW(tl), .TMR_ABOVE_ZERO(tz), .GATE_BELOW_TH(gb),
		.MAIN_GATE_HIGH(gh), .AUX_GATE_HIGH(ah));

	// verdict and end of run, shared with the watchdog
	task automatic final_report();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// wait n edges, then let their updates land
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// single output bit compare
	task automatic chk_bit(input string nm, input logic got, input logic e);
		check_count++;
		if (got !== e)
		begin
			n_errors++;
			$display("unexpected %s expected %b seen %b", nm, e, got);
		end
	endtask

	// one-cycle write strobe
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe edge
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		adr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdd;
	endtask

	// masked register compare
	task automatic chk_reg(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] d;
		rd_reg(a, d);
		check_count++;
		if ((d & m) !== e)
		begin
			n_errors++;
			$display("unexpected reg %h expected %h seen %h", a, e, d & m);
		end
	endtask

	// poll the state field, bounded
	task automatic wait_st(input logic [3:0] st, input int lim_n);
		logic [31:0] d;
		d = '0;
		for (int i = 0; i < lim_n; i++)
		begin
			rd_reg(ADDR_STATUS, d);
			if (d[3:0] === st)
				return;
		end
		n_errors++;
		$display("unexpected state expected %h seen %h", st, d[3:0]);
		final_report();
	endtask

	// watchdog against a hung sequence
	initial
	begin
		repeat (100000) @(posedge clk);
		n_errors++;
		$display("unexpected run length expected end seen hang");
		final_report();
	end

	// main sequence
	initial
	begin
		cyc(3);
		chk_bit("ss discharge in reset", ssd, 1'b1);
		chk_bit("gate in reset", gen, 1'b0);
		@(posedge clk);
		rst <= 1'b0;
		ld <= 1'b0;
		chk_reg(ADDR_CONTROL, 32'hFFFF_FFFF, CONTROL_RST);
		chk_reg(ADDR_INT_EN, 32'hFFFF_FFFF, 32'h0000_0000);
		chk_reg(ADDR_INT_CLEAR, 32'hFFFF_FFFF, 32'h0000_0000);
		wr_reg(8'h14, 32'hFFFF_FFFF);
		chk_reg(8'h14, 32'hFFFF_FFFF, 32'h0000_0000);
		wait_st(ST_OFF, 10);
		chk_bit("no flush on low timer", fls, 1'b0);
		chk_bit("small sink when off", snk, 1'b1);
		// hold keeps the block off with a valid input
		wr_reg(ADDR_CONTROL, 32'h0000_0001);
		vld <= 1'b1;
		cyc(8);
		chk_reg(ADDR_STATUS, 32'h0000_000F, 32'h0000_0001);
		wr_reg(ADDR_CONTROL, 32'h0000_0000);
		wait_st(ST_INS_DELAY, 10);
		chk_bit("ss switch in delay", ssw, 1'b0);
		chk_bit("ss discharge in delay", ssd, 1'b1);
		wait_st(ST_STARTUP, 30);
		chk_bit("ss switch in start", ssw, 1'b1);
		chk_bit("ss discharge in start", ssd, 1'b0);
		chk_bit("low limit in start", hl, 1'b0);
		chk_bit("low fast trip in start", ftl, 1'b1);
		chk_bit("aux off in start", aen, 1'b0);
		pgd <= 1'b1;
		wait_st(ST_NORMAL, 10);
		cyc(40);
		chk_bit("ss switch normal", ssw, 1'b0);
		chk_bit("ss discharge normal", ssd, 1'b0);
		chk_bit("high limit low drain", hl, 1'b1);
		chk_bit("aux on when main up", aen, 1'b1);
		chk_bit("power good", pgi, 1'b1);
		chk_bit("small sink no limit", snk, 1'b1);
		chk_bit("gate on normal", gen, 1'b1);
		chk_bit("no pull low normal", gpl, 1'b0);
		chk_bit("full fast trip normal", ftl, 1'b0);
		// every select pin code
		for (int i = 0; i < 4; i++)
		begin
			thr <= 2'(i);
			cyc(5);
			chk_bit("limit 40mv", l40, i[1]);
			chk_bit("fast trip 3x", x3, i[1] ^ i[0]);
		end
		dt <= 1'b1;
		cyc(5);
		chk_bit("power good high drain", pgi, 1'b0);
		dl <= 1'b1;
		cyc(5);
		chk_bit("low limit high drain", hl, 1'b0);
		// fast trip drops both gates but stays in normal
		wr_reg(ADDR_INT_EN, 32'h0000_0002);
		@(posedge clk);
		ft <= 1'b1;
		cyc(3);
		chk_bit("fast trip pull low", gpl, 1'b1);
		chk_bit("fast trip gate off", gen, 1'b0);
		cyc(1);
		chk_bit("irq on fast trip", irq, 1'b1);
		ft <= 1'b0;
		chk_reg(ADDR_STATUS, 32'h0000_000F, 32'h0000_0004);
		wr_reg(ADDR_INT_EN, 32'h0000_0000);
		cyc(2);
		chk_bit("irq masked", irq, 1'b0);
		wr_reg(ADDR_INT_CLEAR, 32'h0000_0002);
		wr_reg(ADDR_INT_EN, 32'h0000_0002);
		cyc(2);
		chk_bit("irq cleared", irq, 1'b0);
		chk_reg(ADDR_INT_STAT, 32'h0000_0002, 32'h0000_0000);
		// current limit, slow then fast source
		dl <= 1'b0;
		cyc(30);
		lim <= 1'b1;
		cyc(6);
		chk_bit("low source", slo, 1'b1);
		chk_bit("sink off in limit", snk, 1'b0);
		dl <= 1'b1;
		cyc(5);
		chk_bit("high source", shi, 1'b1);
		wait_st(ST_COOL_DIS, 30);
		chk_bit("timed out below high", th, 1'b0);
		chk_reg(ADDR_INT_STAT, 32'h0000_0001, 32'h0000_0001);
		lim <= 1'b0;
		pgd <= 1'b0;
		vld <= 1'b0;
		cyc(50);
		vld <= 1'b1;
		wait_st(ST_COOL_FLUSH, 15000);
		chk_bit("full discharge", fls, 1'b1);
		chk_reg(ADDR_STATUS, 32'h0000_7F00, 32'h0000_4000);
		chk_reg(ADDR_INT_STAT, 32'h0000_0004, 32'h0000_0004);
		wait_st(ST_STARTUP, 200);
		// second power-on with a charged cap
		@(posedge clk);
		rst <= 1'b1;
		ld <= 1'b1;
		lmv <= 12'h3E8;
		cyc(3);
		rst <= 1'b0;
		ld <= 1'b0;
		wait_st(ST_COOL_DIS, 10);
		chk_reg(ADDR_STATUS, 32'h0000_7F00, 32'h0000_0000);
		final_report();
	end
endmodule
